// >>> core/caf_pkg.sv
`default_nettype none
package caf_pkg;

  // register word indices; byte address is four times the index
  localparam logic [11:0] IDX_CODE0    = 12'h110;
  localparam logic [11:0] IDX_CODE1    = 12'h111;
  localparam logic [11:0] IDX_CODE2    = 12'h112;
  localparam logic [11:0] IDX_CODE3    = 12'h113;
  localparam logic [11:0] IDX_CODE4    = 12'h118;
  localparam logic [11:0] IDX_CODE5    = 12'h119;
  localparam logic [11:0] IDX_CODE6    = 12'h11a;
  localparam logic [11:0] IDX_CODE7    = 12'h11b;
  localparam logic [11:0] IDX_MASK0    = 12'h114;
  localparam logic [11:0] IDX_MASK4    = 12'h11c;
  localparam logic [11:0] IDX_RXERR    = 12'h10e;
  localparam logic [11:0] IDX_TXERR    = 12'h10f;
  localparam logic [11:0] IDX_CTRL     = 12'h120;
  localparam logic [11:0] IDX_FMODE    = 12'h121;
  localparam logic [11:0] IDX_PCTL     = 12'h13d;
  localparam logic [11:0] IDX_PDATA    = 12'h13e;
  localparam logic [11:0] IDX_PDIR     = 12'h13f;

  // field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int PULLUP_BIT     = 1;
  localparam int REDDRV_BIT     = 0;
  localparam int TX_PIN_BIT     = 1;
  localparam int RX_PIN_BIT     = 0;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [5:0] GP_ZERO    = 6'h00;
  localparam logic [2:0] HIT_ZERO   = 3'h0;

  // filter organisation
  typedef enum logic [1:0] {
    CAF_TWO_32   = 2'h0,
    CAF_FOUR_16  = 2'h1,
    CAF_EIGHT_8  = 2'h2,
    CAF_CLOSED   = 2'h3
  } caf_mode_t;

  // identifier presented by the receiver with its format
  typedef struct packed {
    logic [3:0][7:0] idByte;
    logic            extended;
  } caf_frame_t;

  // acceptance result of one frame
  typedef struct packed {
    logic       accept;
    logic [2:0] hit;
  } caf_result_t;

endpackage : caf_pkg
`default_nettype wire

// >>> core/caf_match.sv
`timescale 1ns/100ps
`default_nettype none
// combinational acceptance decision over eight code/mask pairs
module caf_match (
  input  wire logic [7:0][7:0]     code,
  input  wire logic [7:0][7:0]     mask,
  input  wire caf_pkg::caf_mode_t  mode,
  input  wire caf_pkg::caf_frame_t frame,
  output caf_pkg::caf_result_t     result
);

  logic [7:0] byteOk;
  logic [7:0] pairOk;
  logic [7:0] hitVec;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gByte
      assign byteOk[g] = &(~(code[g] ^ frame.idByte[g % 4]) | mask[g]);
      // 16-bit filters all look at identifier bytes zero and one
      assign pairOk[g] = &(~(code[g] ^ frame.idByte[g % 2]) | mask[g]);
    end
  endgenerate

  // filter hit vector per mode
  always_comb begin
    hitVec = 8'h00;
    case (mode)
      caf_pkg::CAF_TWO_32: begin
        hitVec[0] = &byteOk[1:0] & (~frame.extended | &byteOk[3:2]);
        hitVec[1] = &byteOk[5:4] & (~frame.extended | &byteOk[7:6]);
      end
      caf_pkg::CAF_FOUR_16: begin
        hitVec[0] = &pairOk[1:0];
        hitVec[1] = &pairOk[3:2];
        hitVec[2] = &pairOk[5:4];
        hitVec[3] = &pairOk[7:6];
      end
      caf_pkg::CAF_EIGHT_8: hitVec = byteOk;
      default: hitVec = 8'h00;
    endcase
  end

  // lowest matching filter wins
  always_comb begin
    result.accept = |hitVec;
    result.hit    = caf_pkg::HIT_ZERO;
    for (int i = 7; i >= 0; i--) begin
      if (hitVec[i]) begin
        result.hit = 3'(i);
      end
    end
  end

endmodule // caf_match
`default_nettype wire

// >>> core/caf_top.sv
// Notes on behaviour
// - receive error count readable only; writes do nothing.
// - transmit error count readable only; writes do nothing.
// - frame buffered only when filter accepts; CPU told then.
// - compare identifier bytes zero to three bit by bit.
// - extended uses four pairs, standard only first two.
// - compare code bit to identifier bit, qualify by mask.
// - code registers writable only while soft reset is set.
// - mask registers writable only while soft reset is set.
// - mask zero must equal, mask one ignored; all must match.
// - bits seven to two general purpose; one transmit, zero receive.
// - pull-up enable bit turns port pull devices on.
// - reduced drive bit selects reduced output strength.
// - data write sets latch; driven only when direction is one.
// - read gives latch when output, pin level when input.
// - data bits one and zero read transmit and receive pins.
// - direction zero input, one output, bits seven to two.
// - mode 00 two 32, 01 four 16, 10 eight 8, 11 closed.
// - hit index updated when frame moves to foreground.
`timescale 1ns/100ps
`default_nettype none
module caf_top (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                clkEn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [15:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // from the protocol engine
  input  wire logic [7:0]          rxErrCount,
  input  wire logic [7:0]          txErrCount,
  input  wire logic                frameValid,
  input  wire caf_pkg::caf_frame_t frameIn,
  input  wire logic                fgRelease,
  input  wire logic                txBit,
  // to the protocol engine
  output logic                     frameAccepted,
  output logic                     fgFull,
  output logic [2:0]               filterHitIndex,
  output logic                     softReset,
  // pins
  input  wire logic [7:0]          portPinIn,
  output logic [7:2]               portPinOut,
  output logic [7:2]               portPinOe,
  output logic                     busTransmitPin,
  output logic                     portPullupEnable,
  output logic                     portReducedDrive
);

  // whole state of the block
  typedef struct packed {
    logic [7:0][7:0] code;
    logic [7:0][7:0] mask;
    logic [7:0]      ctrl;
    logic [1:0]      mode;
    logic [7:0]      pctl;
    logic [7:2]      latch;
    logic [7:2]      dir;
    logic [2:0]      hit;
    logic            fg;
    logic            accPulse;
    logic            ready;
    logic [31:0]     rdata;
    logic            err;
    logic [7:0]      s1;
    logic [7:0]      s2;
    logic [7:0]      s3;
    logic [7:0]      pinLvl;
    logic            txOut;
  } caf_state_t;

  caf_state_t st;
  caf_state_t next_st;
  caf_pkg::caf_result_t matchRes;

  logic       setup;
  logic       doWrite;
  logic [11:0] idx;
  logic [7:0] wbyte;
  logic       frozen;
  logic [7:0] portRead;

  caf_match uMatch (
    .code   (st.code),
    .mask   (st.mask),
    .mode   (caf_pkg::caf_mode_t'(st.mode)),
    .frame  (frameIn),
    .result (matchRes)
  );

  // bus decode
  assign setup   = psel & ~penable;
  assign doWrite = psel & penable & st.ready & pwrite;
  assign idx     = paddr[13:2];
  assign wbyte   = pwdata[7:0];
  assign frozen  = st.ctrl[caf_pkg::SOFT_RESET_BIT];

  // port data readback
  always_comb begin
    portRead = caf_pkg::BYTE_ZERO;
    for (int b = 2; b < 8; b++) begin
      portRead[b] = st.dir[b] ? st.latch[b] : st.pinLvl[b];
    end
    portRead[caf_pkg::TX_PIN_BIT] = st.txOut;
    portRead[caf_pkg::RX_PIN_BIT] = st.pinLvl[caf_pkg::RX_PIN_BIT];
  end

  // next state
  always_comb begin
    next_st          = st;
    next_st.accPulse = 1'b0;
    // pins pass three stages, change taken when two and three agree
    next_st.s1 = portPinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.pinLvl = st.s3;
    end
    next_st.txOut = txBit;

    // no wait state: answer in the first access cycle
    next_st.ready = setup;
    next_st.err   = 1'b0;
    if (setup) begin
      next_st.rdata = 32'h0000_0000;
      case (idx)
        caf_pkg::IDX_CODE0, caf_pkg::IDX_CODE1,
        caf_pkg::IDX_CODE2, caf_pkg::IDX_CODE3:
          next_st.rdata[7:0] = st.code[idx[1:0]];
        caf_pkg::IDX_CODE4, caf_pkg::IDX_CODE5,
        caf_pkg::IDX_CODE6, caf_pkg::IDX_CODE7:
          next_st.rdata[7:0] = st.code[{1'b1, idx[1:0]}];
        caf_pkg::IDX_MASK0, caf_pkg::IDX_MASK0 + 12'h001,
        caf_pkg::IDX_MASK0 + 12'h002, caf_pkg::IDX_MASK0 + 12'h003:
          next_st.rdata[7:0] = st.mask[idx[1:0]];
        caf_pkg::IDX_MASK4, caf_pkg::IDX_MASK4 + 12'h001,
        caf_pkg::IDX_MASK4 + 12'h002, caf_pkg::IDX_MASK4 + 12'h003:
          next_st.rdata[7:0] = st.mask[{1'b1, idx[1:0]}];
        caf_pkg::IDX_RXERR: next_st.rdata[7:0] = rxErrCount;
        caf_pkg::IDX_TXERR: next_st.rdata[7:0] = txErrCount;
        caf_pkg::IDX_CTRL:  next_st.rdata[7:0] = st.ctrl;
        caf_pkg::IDX_FMODE: next_st.rdata[7:0] = {1'b0, st.hit, 2'b00, st.mode};
        caf_pkg::IDX_PCTL:  next_st.rdata[7:0] = st.pctl;
        caf_pkg::IDX_PDATA: next_st.rdata[7:0] = portRead;
        caf_pkg::IDX_PDIR:  next_st.rdata[7:0] = {st.dir, 2'b00};
        default:            next_st.err = 1'b1;
      endcase
    end

    // register writes; count registers ignore them
    if (doWrite) begin
      case (idx)
        caf_pkg::IDX_CODE0, caf_pkg::IDX_CODE1,
        caf_pkg::IDX_CODE2, caf_pkg::IDX_CODE3:
          if (frozen) next_st.code[idx[1:0]] = wbyte;
        caf_pkg::IDX_CODE4, caf_pkg::IDX_CODE5,
        caf_pkg::IDX_CODE6, caf_pkg::IDX_CODE7:
          if (frozen) next_st.code[{1'b1, idx[1:0]}] = wbyte;
        caf_pkg::IDX_MASK0, caf_pkg::IDX_MASK0 + 12'h001,
        caf_pkg::IDX_MASK0 + 12'h002, caf_pkg::IDX_MASK0 + 12'h003:
          if (frozen) next_st.mask[idx[1:0]] = wbyte;
        caf_pkg::IDX_MASK4, caf_pkg::IDX_MASK4 + 12'h001,
        caf_pkg::IDX_MASK4 + 12'h002, caf_pkg::IDX_MASK4 + 12'h003:
          if (frozen) next_st.mask[{1'b1, idx[1:0]}] = wbyte;
        caf_pkg::IDX_CTRL:  next_st.ctrl = wbyte;
        caf_pkg::IDX_FMODE: if (frozen) next_st.mode = wbyte[1:0];
        caf_pkg::IDX_PCTL:  next_st.pctl = wbyte;
        caf_pkg::IDX_PDATA: next_st.latch = wbyte[7:2];
        caf_pkg::IDX_PDIR:  next_st.dir = wbyte[7:2];
        default: ;
      endcase
    end

    // foreground buffer handshake
    if (fgRelease) begin
      next_st.fg = 1'b0;
    end
    if (frameValid && !frozen && matchRes.accept && !st.fg) begin
      next_st.fg       = 1'b1;
      next_st.accPulse = 1'b1;
      next_st.hit      = matchRes.hit;
    end
    if (frozen) begin
      next_st.fg  = 1'b0;
      next_st.hit = caf_pkg::HIT_ZERO;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st      <= '0;
      st.ctrl <= caf_pkg::CTRL_RESET;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign pready           = st.ready;
  assign prdata           = st.rdata;
  assign pslverr          = st.err;
  assign frameAccepted    = st.accPulse;
  assign fgFull           = st.fg;
  assign filterHitIndex   = st.hit;
  assign softReset        = st.ctrl[caf_pkg::SOFT_RESET_BIT];
  assign busTransmitPin   = st.txOut;
  assign portPinOut       = st.latch;
  assign portPinOe        = st.dir;
  assign portPullupEnable = st.pctl[caf_pkg::PULLUP_BIT];
  assign portReducedDrive = st.pctl[caf_pkg::REDDRV_BIT];

endmodule // caf_top
`default_nettype wire

// >>> verification/caf_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module caf_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frameValid,
  input wire logic fgRelease,
  input wire logic txBit,
  input wire logic frameAccepted,
  input wire logic fgFull,
  input wire logic softReset,
  input wire logic busTransmitPin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // setup cycle then access cycle
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  a_ready_after_setup: assert property (s_setup |-> pready)
    else $error("ready missing");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_accept_cause: assert property (frameAccepted |->
    $past(frameValid) && !$past(fgFull) && !$past(softReset))
    else $error("accept without frame");
  a_accept_fills: assert property (frameAccepted |-> fgFull)
    else $error("accept left buffer empty");
  a_full_holds: assert property (fgFull && !fgRelease && !softReset
    |=> fgFull || softReset)
    else $error("buffer dropped");
  a_soft_clears: assert property (softReset |=> !fgFull)
    else $error("buffer full in soft reset");
  a_tx_follows: assert property ($past(rstn) |->
    busTransmitPin == $past(txBit))
    else $error("transmit pin lag");
endmodule // caf_chk
bind caf_top caf_chk u_chk (.clk, .rstn, .psel, .penable, .pready,
  .pslverr, .frameValid, .fgRelease, .txBit, .frameAccepted, .fgFull,
  .softReset, .busTransmitPin);
`default_nettype wire

// >>> verification/caf_node_model.sv
`timescale 1ns/100ps
`default_nettype none
module caf_node_model (
  input wire logic       clk,
  input wire logic       rxLevel,
  input wire logic       busTransmitPin,
  input wire logic [7:2] portPinOut,
  input wire logic [7:2] portPinOe,
  input wire logic       portPullupEnable,
  input wire logic [7:2] extLevel,
  input wire logic       extOn,
  output logic [7:0]     portPinIn
);
  logic tog = 1'b0;
  // floating pins wander every cycle
  always @(posedge clk) tog <= ~tog;
  // resolve each pin from all drivers
  always_comb begin
    for (int i = 2; i < 8; i++) begin
      if (portPinOe[i]) portPinIn[i] = portPinOut[i];
      else if (extOn) portPinIn[i] = extLevel[i];
      else portPinIn[i] = portPullupEnable ? 1'b1 : tog;
    end
    portPinIn[1] = busTransmitPin;
    portPinIn[0] = rxLevel;
  end
endmodule // caf_node_model
`default_nettype wire

// >>> verification/caf_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module caf_top_bench;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic frameValid = 0, fgRelease = 0, txBit = 0, rxLevel = 0, extOn = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] rxErrCount = 0, txErrCount = 0, portPinIn, code[8], mask[8];
  logic [7:2] portPinOut, portPinOe, extLevel = 0;
  logic [2:0] filterHitIndex;
  logic pready, pslverr, er, frameAccepted, fgFull, softReset, fullM;
  logic busTransmitPin, portPullupEnable, portReducedDrive;
  caf_pkg::caf_frame_t frameIn = '0;
  int err_count = 0, cmp_count = 0, cyc = 0;
  logic [7:0] dir, dat, pc, e;

  always #2 clk = ~clk;
  caf_top u_dut (.clk, .rstn, .clkEn(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .rxErrCount, .txErrCount,
    .frameValid, .frameIn, .fgRelease, .txBit, .frameAccepted, .fgFull,
    .filterHitIndex, .softReset, .portPinIn, .portPinOut, .portPinOe,
    .busTransmitPin, .portPullupEnable, .portReducedDrive);
  caf_node_model u_node (.clk, .rxLevel, .busTransmitPin, .portPinOut,
    .portPinOe, .portPullupEnable, .extLevel, .extOn, .portPinIn);

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      err_count++;
      $display("unexpected at %0t: %h expected %h", $time, s, x);
    end
  endtask
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one apb transfer, waits for ready
  task automatic apb(input logic w, input logic [11:0] ix,
                     input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 50) err_count++;
  endtask
  function automatic logic [11:0] cix(int i);
    return caf_pkg::IDX_CODE0 + 12'(i) + (i >= 4 ? 12'h4 : 12'h0);
  endfunction
  function automatic int pr(int m, int k, int j);
    return m == 0 ? 4*k+j : m == 1 ? 2*k+j%2 : k;
  endfunction
  // identifier byte seen by a pair: 16-bit filters use bytes 0 and 1
  function automatic int ib(int m, int p);
    return m == 1 ? p % 2 : p % 4;
  endfunction
  function automatic int hit(int m, logic [31:0] id, logic ext);
    int nf = m == 0 ? 2 : m == 1 ? 4 : m == 2 ? 8 : 0;
    int nb = m == 0 ? (ext ? 4 : 2) : m == 1 ? 2 : 1;
    logic ok;
    for (int k = 0; k < nf; k++) begin
      ok = 1;
      for (int j = 0; j < nb; j++)
        if (((code[pr(m,k,j)] ^ id[8*ib(m,pr(m,k,j))+:8])
             & ~mask[pr(m,k,j)]) != 0) ok = 0;
      if (ok) return k;
    end
    return -1;
  endfunction
  // one frame, optionally built to hit filter k
  task automatic frm(input int m, input int k, input logic ext);
    logic [31:0] id = $urandom;
    int nf = m == 0 ? 2 : m == 1 ? 4 : m == 2 ? 8 : 1;
    int h;
    logic acc;
    if (k >= 0) for (int j = 0; j < 4; j++) id[8*j+:8] =
      code[pr(m,k%nf,j)] ^ (8'($urandom) & mask[pr(m,k%nf,j)]);
    h = hit(m, id, ext);
    acc = h >= 0 && !fullM;
    @(posedge clk);
    frameIn <= {id, ext}; frameValid <= 1;
    @(posedge clk);
    frameValid <= 0;
    @(negedge clk);
    if (acc) fullM = 1;
    chk(frameAccepted, acc);
    chk(fgFull, fullM);
    if (acc) chk(filterHitIndex, h[2:0]);
  endtask

  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin err_count++; report_and_stop; end
  end
  // main sequence
  initial begin
    void'($urandom(63));
    repeat (10) @(posedge clk);
    rstn <= 1;
    apb(0, caf_pkg::IDX_CTRL, 0); chk(rd, 32'h1);
    rxErrCount <= 8'($urandom); txErrCount <= 8'($urandom);
    apb(1, caf_pkg::IDX_RXERR, 8'hff); apb(1, caf_pkg::IDX_TXERR, 8'hff);
    apb(0, caf_pkg::IDX_RXERR, 0); chk(rd, rxErrCount);
    apb(0, caf_pkg::IDX_TXERR, 0); chk(rd, txErrCount);
    apb(0, 12'h100, 0); chk(er, 1'b1);
    for (int m = 0; m < 4; m++) begin
      apb(1, caf_pkg::IDX_CTRL, 1); fullM = 0;
      for (int i = 0; i < 8; i++) begin
        code[i] = 8'($urandom); mask[i] = 8'($urandom);
        // standard ids ignore low id bits
        if (m < 2 && i % 2 == 1 && (m == 1 || i % 4 == 1))
          mask[i][2:0] = 3'h7;
        apb(1, cix(i), code[i]); apb(1, cix(i) + 12'h4, mask[i]);
      end
      apb(1, caf_pkg::IDX_FMODE, 8'(m)); apb(1, caf_pkg::IDX_CTRL, 0);
      apb(0, caf_pkg::IDX_FMODE, 0); chk(rd, m);
      apb(1, cix(m), ~code[m]); apb(1, cix(m) + 12'h4, ~mask[m]);
      apb(0, cix(m), 0); chk(rd, code[m]);
      apb(0, cix(m) + 12'h4, 0); chk(rd, mask[m]);
      for (int n = 0; n < 12; n++) begin
        frm(m, n < 8 ? n : -1, 1'($urandom));
        if (n != 2) begin
          @(posedge clk) fgRelease <= 1;
          @(posedge clk) fgRelease <= 0;
          fullM = 0;
        end
      end
    end
    for (int t = 0; t < 6; t++) begin
      dir = 8'($urandom); dat = 8'($urandom); pc = 8'($urandom);
      txBit <= $urandom; rxLevel <= $urandom; extOn <= $urandom;
      extLevel <= $urandom;
      apb(1, caf_pkg::IDX_PCTL, pc); apb(1, caf_pkg::IDX_PDIR, dir);
      apb(1, caf_pkg::IDX_PDATA, dat);
      repeat (5) @(posedge clk);
      apb(0, caf_pkg::IDX_PDATA, 0);
      chk(portPinOe, dir[7:2]);
      chk(portPinOut, dat[7:2]);
      chk({portPullupEnable, portReducedDrive}, pc[1:0]);
      e = {dir[7:2] & dat[7:2] | ~dir[7:2] & (extOn ? extLevel
           : 6'h3f), txBit, rxLevel};
      if (extOn || pc[1]) chk(rd, e);
    end
    report_and_stop;
  end
endmodule // caf_top_bench
`default_nettype wire
